// [shared/rss_pkg.sv]
// Shared constants and types for the two-wire clock serial slave and its bus master
package rss_pkg;

   // Fixed 7-bit device address, pattern 0110010
   localparam logic [6:0] RSS_DEV_ADDR = 7'h32;
   // Register pointer value loaded by every stop and by the timeout
   localparam logic [3:0] RSS_PTR_AFTER_STOP = 4'hF;
   // Transfer-format nibble that turns the link around straight after the pointer byte
   localparam logic [3:0] RSS_FMT_READ_NOW = 4'h4;
   // Bit counter positions: last data bit, acknowledge bit, before the first bit
   localparam logic [3:0] RSS_BIT_LAST_DATA = 4'h7;
   localparam logic [3:0] RSS_BIT_ACK = 4'h8;
   localparam logic [3:0] RSS_BIT_PRE = 4'hF;
   // Value of the register store after reset
   localparam logic [7:0] RSS_REG_RESET = 8'h00;

   // Access timeout: 0.5 s measured on the link clock
   localparam int RSS_LINK_PERIOD_NS = 160;
   localparam int RSS_TIMEOUT_MS = 500;
   localparam int RSS_TIMEOUT_CYC = RSS_TIMEOUT_MS * 1000000 / RSS_LINK_PERIOD_NS;

   // Bus master: clk cycles per quarter of one serial bit
   localparam int RSS_QTR_CYC = 16;
   localparam logic [3:0] RSS_QTR_LAST = 4'(RSS_QTR_CYC - 1);
   localparam logic [1:0] RSS_QTR_END = 2'h3;

   // Device byte-engine states
   typedef enum logic [2:0] {
      RSS_DS_IDLE = 3'h0,
      RSS_DS_ADDR = 3'h1,
      RSS_DS_PTR = 3'h3,
      RSS_DS_WR = 3'h2,
      RSS_DS_RD = 3'h6
   } rss_dstate_t;

   // Bus master commands
   typedef enum logic [1:0] {
      RSS_OP_START = 2'h0,
      RSS_OP_STOP = 2'h1,
      RSS_OP_WRITE = 2'h3,
      RSS_OP_READ = 2'h2
   } rss_op_t;

   // Bus master sequencer states
   typedef enum logic {
      RSS_HS_IDLE = 1'b0,
      RSS_HS_RUN = 1'b1
   } rss_hstate_t;

endpackage

// [shared/rss_if.sv]
// Two-wire bus between the bus master and the clock serial slave, with pull-ups
`timescale 1ns/1ns
`default_nettype none
interface rss_if;
   logic host_scl_o;
   logic host_scl_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic scl;
   logic sda;

   // Open-drain wires: low while any enabled driver drives low, else pulled high
   assign scl = !(!host_scl_oe_n && !host_scl_o);
   assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));

   modport host (
      output host_scl_o,
      output host_scl_oe_n,
      output host_sda_o,
      output host_sda_oe_n,
      input sda
   );

   modport dev (
      output dev_sda_o,
      output dev_sda_oe_n,
      input scl,
      input sda
   );
endinterface
`default_nettype wire

// [verilog/rss_host.sv]
// Bus master end: makes the serial clock by division and runs start, stop and byte commands
`timescale 1ns/1ns
`default_nettype none
module rss_host
   import rss_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   rss_if.host bus,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire rss_op_t cmd_op,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_last,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_ack
);
   rss_hstate_t st;
   rss_op_t op;
   logic [1:0] qtr;
   logic [3:0] qcnt;
   logic [3:0] bitn;
   logic [7:0] sh;
   logic last;
   logic scl_low;
   logic sda_low;
   logic sda_m;
   logic sda_s;
   logic out_bit;
   logic is_byte;

   // Bus pin is foreign to clk: two flops before use
   always_ff @(posedge clk) begin
      sda_m <= bus.sda;
      sda_s <= sda_m;
   end

   // Open-drain drive: enable low only while pulling a line low
   assign bus.host_scl_o = 1'b0;
   assign bus.host_sda_o = 1'b0;
   assign bus.host_scl_oe_n = ~scl_low;
   assign bus.host_sda_oe_n = ~sda_low;
   assign cmd_ready = (st == RSS_HS_IDLE);
   assign is_byte = (op == RSS_OP_WRITE) || (op == RSS_OP_READ);

   // Bit put on the line: data msb first, then released or own acknowledge
   always_comb begin
      if (bitn == RSS_BIT_ACK) begin
         out_bit = (op == RSS_OP_READ) ? last : 1'b1;
      end else begin
         out_bit = (op == RSS_OP_READ) ? 1'b1 : sh[7];
      end
   end

   // Quarter-bit sequencer; each action is taken in the first cycle of its quarter
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= RSS_HS_IDLE;
         op <= RSS_OP_START;
         qtr <= 2'h0;
         qcnt <= 4'h0;
         bitn <= 4'h0;
         sh <= 8'h00;
         last <= 1'b0;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_ack <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         case (st)
            RSS_HS_IDLE: begin
               if (cmd_valid) begin
                  st <= RSS_HS_RUN;
                  op <= cmd_op;
                  sh <= cmd_data;
                  last <= cmd_last;
                  qtr <= 2'h0;
                  qcnt <= 4'h0;
                  bitn <= 4'h0;
               end
            end
            RSS_HS_RUN: begin
               if (qcnt == 4'h0) begin
                  case (op)
                     // start only ever comes from this end
                     RSS_OP_START: begin
                        case (qtr)
                           2'h0: sda_low <= 1'b0;
                           2'h1: scl_low <= 1'b0;
                           2'h2: sda_low <= 1'b1;
                           default: scl_low <= 1'b1;
                        endcase
                     end
                     // stop, data rising with clock high
                     RSS_OP_STOP: begin
                        case (qtr)
                           2'h0: sda_low <= 1'b1;
                           2'h1: scl_low <= 1'b0;
                           2'h2: sda_low <= 1'b0;
                           default: sda_low <= 1'b0;
                        endcase
                     end
                     // eight data bits then acknowledge bit
                     default: begin
                        case (qtr)
                           2'h0: sda_low <= ~out_bit;
                           2'h1: scl_low <= 1'b0;
                           2'h2: begin
                              if (bitn == RSS_BIT_ACK) begin
                                 rsp_ack <= ~sda_s;
                              end else begin
                                 sh <= {sh[6:0], sda_s};
                              end
                           end
                           default: scl_low <= 1'b1;
                        endcase
                     end
                  endcase
               end
               if (qcnt == RSS_QTR_LAST) begin
                  qcnt <= 4'h0;
                  qtr <= qtr + 2'h1;
                  if (qtr == RSS_QTR_END) begin
                     if (is_byte && bitn != RSS_BIT_ACK) begin
                        bitn <= bitn + 4'h1;
                     end else begin
                        st <= RSS_HS_IDLE;
                        rsp_valid <= is_byte;
                        rsp_data <= sh;
                     end
                  end
               end else begin
                  qcnt <= qcnt + 4'h1;
               end
            end
            default: st <= RSS_HS_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// [verilog/rss_dev.sv]
// Clock serial slave end: start/stop, addressing, pointer, reads, writes, freeze and timeout
// Summary of operation
// - Start opens access, stop closes it
// - Only the master makes start and stop
// - Eight-bit bytes, receiver acknowledges low on ninth
// - Receiver releases at ninth fall unless transmitting
// - Master nack ends read; device releases line
// - First byte: 7-bit address msb first, direction
// - Answer only address 0110010
// - Repeated start resends address, may change direction
// - Second write byte: pointer and format nibble
// - Third byte stored at pointer, then pointer increments
// - Pointer wraps from Fh to 0h
// - Every stop loads pointer with Fh
// - Standard read: pointer, then repeated start read
// - Format 4h returns data right after pointer
// - Read straight after address uses current pointer
// - Freeze carries during access, apply after stop
// - Timeout ends access as if stopped
// - Repeated starts do not restart timeout
// - After timeout: no write ack, reads FFh
// - Master finishes within 0.5 s, waits after stop
// - Bus outputs only pull low, open drain
`timescale 1ns/1ns
`default_nettype none
module rss_dev
   import rss_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = RSS_TIMEOUT_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic link_clk,
   rss_if.dev bus,
   input wire logic carry_in,
   output logic carry_out,
   output logic freeze,
   output logic reg_wr,
   output logic [3:0] reg_wr_addr,
   output logic [7:0] reg_wr_data
);
   // Link-domain state
   logic lrst_m, lrst, scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
   logic start_cond, stop_cond, scl_rise, scl_fall;
   rss_dstate_t st;
   logic [3:0] bcnt, ptr, fmt, wr_addr_l;
   logic [7:0] rx, tx, cur, wr_data_l;
   logic drv_low, rw, m_ack, acc_open, expired, tmo_hit, wr_tgl;
   logic [7:0] regs [16];
   logic [31:0] tmo_cnt;
   // System-domain state
   logic frz_m, frz_s, wt_m, wt_s, wt_q, pend;

   // Reset and both bus lines come from other domains: two flops each
   always_ff @(posedge link_clk) begin
      lrst_m <= sys_rst;
      lrst <= lrst_m;
      scl_m <= bus.scl;
      scl_s <= scl_m;
      sda_m <= bus.sda;
      sda_s <= sda_m;
   end

   // One-cycle history for edge and condition detection
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   // data edges while the clock stays high
   assign start_cond = scl_s && scl_q && sda_q && !sda_s;
   assign stop_cond = scl_s && scl_q && !sda_q && sda_s;
   assign scl_rise = scl_s && !scl_q;
   assign scl_fall = !scl_s && scl_q;
   assign cur = regs[ptr];

   // only ever pull low; released otherwise
   assign bus.dev_sda_o = 1'b0;
   assign bus.dev_sda_oe_n = ~drv_low;

   // counter runs from the first start only
   assign tmo_hit = acc_open && (tmo_cnt == 32'(TIMEOUT_CYCLES - 1));

   // Access window and timeout counter
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         acc_open <= 1'b0;
         expired <= 1'b0;
         tmo_cnt <= 32'h0;
      end else if (stop_cond) begin
         // stop closes the access and clears a past timeout
         acc_open <= 1'b0;
         expired <= 1'b0;
         tmo_cnt <= 32'h0;
      end else if (tmo_hit) begin
         // end the access on its own
         acc_open <= 1'b0;
         expired <= 1'b1;
         tmo_cnt <= 32'h0;
      end else if (start_cond && !acc_open && !expired) begin
         acc_open <= 1'b1;
         tmo_cnt <= 32'h0;
      end else if (acc_open) begin
         tmo_cnt <= tmo_cnt + 32'h1;
      end
   end

   // Byte engine: sample on rising clock, change drive after the falling clock, release it at start, stop or timeout
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         st <= RSS_DS_IDLE;
         bcnt <= RSS_BIT_PRE;
         rx <= 8'h00;
         tx <= 8'h00;
         drv_low <= 1'b0;
         ptr <= RSS_PTR_AFTER_STOP;
         fmt <= 4'h0;
         rw <= 1'b0;
         m_ack <= 1'b0;
         wr_tgl <= 1'b0;
         wr_addr_l <= 4'h0;
         wr_data_l <= 8'h00;
         for (int i = 0; i < 16; i++) begin
            regs[i] <= RSS_REG_RESET;
         end
      end else if (stop_cond || tmo_hit) begin
         // both load the pointer and drop the bus
         ptr <= RSS_PTR_AFTER_STOP;
         st <= RSS_DS_IDLE;
         drv_low <= 1'b0;
      end else if (start_cond) begin
         // a timed-out access ignores starts until a stop
         st <= expired ? RSS_DS_IDLE : RSS_DS_ADDR;
         bcnt <= RSS_BIT_PRE;
         drv_low <= 1'b0;
      end else if (scl_rise) begin
         // address and data arrive msb first
         if (bcnt <= RSS_BIT_LAST_DATA) begin
            rx <= {rx[6:0], sda_s};
         end else if (bcnt == RSS_BIT_ACK) begin
            m_ack <= ~sda_s;
         end
      end else if (scl_fall && st != RSS_DS_IDLE) begin
         if (bcnt == RSS_BIT_PRE) begin
            bcnt <= 4'h0;
         end else if (bcnt < RSS_BIT_LAST_DATA) begin
            bcnt <= bcnt + 4'h1;
            if (st == RSS_DS_RD) begin
               tx <= {tx[6:0], 1'b1};
               drv_low <= ~tx[6];
            end
         end else if (bcnt == RSS_BIT_LAST_DATA) begin
            bcnt <= RSS_BIT_ACK;
            case (st)
               RSS_DS_ADDR: begin
                  if (rx[7:1] == RSS_DEV_ADDR) begin
                     drv_low <= 1'b1;
                     rw <= rx[0];
                  end else begin
                     st <= RSS_DS_IDLE;
                  end
               end
               RSS_DS_PTR: begin
                  drv_low <= 1'b1;
                  ptr <= rx[7:4];
                  fmt <= rx[3:0];
               end
               RSS_DS_WR: begin
                  // store, then step with natural wrap
                  drv_low <= 1'b1;
                  regs[ptr] <= rx;
                  ptr <= ptr + 4'h1;
                  wr_tgl <= ~wr_tgl;
                  wr_addr_l <= ptr;
                  wr_data_l <= rx;
               end
               default: begin
                  // read pointer steps too; line freed for master ack
                  drv_low <= 1'b0;
                  ptr <= ptr + 4'h1;
               end
            endcase
         end else begin
            // ninth fall frees the line or starts transmitting
            bcnt <= 4'h0;
            drv_low <= 1'b0;
            case (st)
               RSS_DS_ADDR: begin
                  // read straight away from the current pointer
                  if (rw) begin
                     st <= RSS_DS_RD;
                     tx <= cur;
                     drv_low <= ~cur[7];
                  end else begin
                     st <= RSS_DS_PTR;
                  end
               end
               RSS_DS_PTR: begin
                  // format 4h turns around without a new start
                  if (fmt == RSS_FMT_READ_NOW) begin
                     st <= RSS_DS_RD;
                     tx <= cur;
                     drv_low <= ~cur[7];
                  end else begin
                     st <= RSS_DS_WR;
                  end
               end
               RSS_DS_RD: begin
                  // no acknowledge from master, keep released
                  if (m_ack) begin
                     tx <= cur;
                     drv_low <= ~cur[7];
                  end else begin
                     st <= RSS_DS_IDLE;
                  end
               end
               default: st <= st;
            endcase
         end
      end
   end

   // Freeze level and write toggle cross into clk through two flops each
   always_ff @(posedge clk) begin
      frz_m <= acc_open;
      frz_s <= frz_m;
      wt_m <= wr_tgl;
      wt_s <= wt_m;
   end

   // Write event: toggle edge; address and data stand still for many serial bits
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wt_q <= 1'b0;
         reg_wr <= 1'b0;
         reg_wr_addr <= 4'h0;
         reg_wr_data <= 8'h00;
      end else begin
         wt_q <= wt_s;
         reg_wr <= wt_s ^ wt_q;
         if (wt_s ^ wt_q) begin
            reg_wr_addr <= wr_addr_l;
            reg_wr_data <= wr_data_l;
         end
      end
   end

   // hold carries while frozen, release a pending one right after
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         freeze <= 1'b0;
         pend <= 1'b0;
         carry_out <= 1'b0;
      end else begin
         freeze <= frz_s;
         pend <= frz_s ? (pend | carry_in) : 1'b0;
         carry_out <= !frz_s && (pend || carry_in);
      end
   end
endmodule
`default_nettype wire

// [dv/rss_props.sv]
// Concurrent checks on the two-wire link between bus master and clock slave
`timescale 1ns/1ns
`default_nettype none
module rss_props (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe_n,
   input wire logic freeze,
   input wire logic carry_in,
   input wire logic carry_out,
   input wire logic reg_wr,
   input wire logic [3:0] reg_wr_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic have;
   logic [3:0] last;
   logic pend;

   // Last index written in this run; a start may load a new pointer
   always_ff @(posedge clk) begin
      if (sys_rst || !freeze || (scl && $fell(sda))) begin
         have <= 1'b0;
      end else if (reg_wr) begin
         have <= 1'b1;
         last <= reg_wr_addr;
      end
   end

   // Carry that arrived while frozen and is still owed
   always_ff @(posedge clk) begin
      if (sys_rst || carry_out) begin
         pend <= 1'b0;
      end else if (carry_in && freeze) begin
         pend <= 1'b1;
      end
   end

   od_drive_a: assert property (!dev_sda_oe_n |-> !dev_sda_o)
      else $error("slave drives data high");
   no_dev_cond_a: assert property ($fell(dev_sda_oe_n) |-> !scl)
      else $error("slave pulled data while clock high");
   open_access_a: assert property (scl && $fell(sda) && !freeze |-> ##[1:40] freeze)
      else $error("start did not open an access");
   close_access_a: assert property (scl && $rose(sda) |-> ##[1:40] !freeze)
      else $error("stop did not close the access");
   wr_in_access_a: assert property (reg_wr |-> freeze ##1 !reg_wr)
      else $error("register write outside an access");
   ptr_step_a: assert property (reg_wr && have |-> reg_wr_addr == last + 4'h1)
      else $error("pointer did not step by one");
   carry_hold_a: assert property (freeze && $past(freeze) |-> !carry_out)
      else $error("carry passed during an access");
   carry_apply_a: assert property ($fell(freeze) && pend |-> ##[0:3] carry_out)
      else $error("held carry not applied after close");
endmodule
`default_nettype wire

// [dv/rtc_serial_slave_access_tb.sv]
// Self-checking bench: bus master and clock slave joined over the two-wire link
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module rtc_serial_slave_access_tb
   import rss_pkg::*;
;
   // Short timeout keeps the run brief: 2000 link cycles are 8000 clk cycles
   localparam int TO_LINK = 2000;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cmd_valid = 1'b0;
   rss_op_t cmd_op = RSS_OP_START;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_last = 1'b0;
   logic carry_in = 1'b0;
   logic cmd_ready, rsp_valid, rsp_ack, carry_out, freeze, reg_wr;
   logic [7:0] rsp_data, reg_wr_data;
   logic [3:0] reg_wr_addr;
   logic [11:0] wq[$];
   int failures = 0;
   int compares = 0;
   int ncar = 0;
   int n;
   time t0;

   // System clock and an unrelated link clock
   initial forever #20 clk = ~clk;
   initial begin
      #37;
      forever #80 link_clk = ~link_clk;
   end

   rss_if i_rss_if ();
   rss_host i_rss_host (.clk(clk), .sys_rst(sys_rst), .bus(i_rss_if), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_last(cmd_last),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
   rss_dev #(.TIMEOUT_CYCLES(TO_LINK)) i_rss_dev (.clk(clk), .sys_rst(sys_rst),
      .link_clk(link_clk), .bus(i_rss_if), .carry_in(carry_in), .carry_out(carry_out),
      .freeze(freeze), .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
   rss_props i_rss_props (.clk(clk), .sys_rst(sys_rst), .scl(i_rss_if.scl), .sda(i_rss_if.sda),
      .dev_sda_o(i_rss_if.dev_sda_o), .dev_sda_oe_n(i_rss_if.dev_sda_oe_n), .freeze(freeze),
      .carry_in(carry_in), .carry_out(carry_out), .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr));

   // Record every register write and carry; falling edge, where outputs have settled
   always @(negedge clk) begin
      if (reg_wr === 1'b1) wq.push_back({reg_wr_addr, reg_wr_data});
      if (carry_out === 1'b1) ncar++;
   end

   task automatic finish_test;
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One master command; bytes wait for the response pulse, start/stop for ready
   task automatic op(input rss_op_t o, input logic [7:0] d, input logic l);
      int k;
      k = 0;
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_op = o;
      cmd_data = d;
      cmd_last = l;
      while (cmd_ready !== 1'b1 && k < 1000) begin
         k++;
         @(negedge clk);
      end
      @(negedge clk);
      cmd_valid = 1'b0;
      while (((o == RSS_OP_WRITE || o == RSS_OP_READ) ? rsp_valid : cmd_ready) !== 1'b1
         && k < 1000) begin
         k++;
         @(negedge clk);
      end
      if (k >= 1000) begin
         failures++;
         finish_test();
      end
   endtask

   task automatic wb(input logic [7:0] d, input logic a);
      op(RSS_OP_WRITE, d, 1'b0);
      `CHK(rsp_ack, a)
   endtask

   task automatic rd(input logic l, input logic [7:0] e);
      op(RSS_OP_READ, 8'h00, l);
      `CHK(rsp_data, e)
   endtask

   // Stop, then keep the bus quiet past the carry settling time
   task automatic stop;
      op(RSS_OP_STOP, 8'h00, 1'b0);
      repeat (1600) @(negedge clk);
   endtask

   initial begin
      // Reset for 5 cycles: longer than one link period, so the link side catches it
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      repeat (20) @(negedge clk);
      carry_in = 1'b1;
      @(negedge clk);
      carry_in = 1'b0;
      repeat (4) @(negedge clk);
      `CHK(ncar, 1) // idle carry passes
      // Write Eh..1h across the wrap, a carry held meanwhile
      op(RSS_OP_START, 8'h00, 1'b0); // open access
      wb(8'h64, 1'b1); // own address
      carry_in = 1'b1;
      @(negedge clk);
      carry_in = 1'b0;
      wb(8'hE0, 1'b1); // pointer byte
      for (int i = 0; i < 4; i++) wb(8'(8'h11 * (i + 1)), 1'b1); // data acked
      `CHK(ncar, 1) // carry frozen
      stop();
      `CHK(ncar, 2) // carry applied
      `CHK(freeze, 1'b0) // access closed
      `CHK(wq.size(), 4) // one write a byte
      for (int i = 0; i < 4; i++) `CHK(wq[i], {4'(4'hE + i), 8'(8'h11 * (i + 1))}) // wrap
      op(RSS_OP_START, 8'h00, 1'b0); // open access
      wb(8'h64, 1'b1); // own address
      wb(8'hE0, 1'b1); // pointer, format 0h
      op(RSS_OP_START, 8'h00, 1'b0); // repeated start
      wb(8'h65, 1'b1); // read direction
      for (int i = 0; i < 4; i++) rd(i == 3, 8'(8'h11 * (i + 1))); // read steps
      stop();
      // Read straight after the pointer byte
      op(RSS_OP_START, 8'h00, 1'b0); // open access
      wb(8'h64, 1'b1); // own address
      wb(8'hE4, 1'b1); // read now
      rd(1'b0, 8'h11); // first byte
      rd(1'b1, 8'h22); // nack ends read
      stop();
      // Read from the pointer that the stop left behind
      op(RSS_OP_START, 8'h00, 1'b0); // open access
      wb(8'h65, 1'b1); // read direction
      rd(1'b0, 8'h22); // from Fh
      rd(1'b1, 8'h33); // wraps to 0h
      stop();
      // Foreign addresses get no acknowledge
      op(RSS_OP_START, 8'h00, 1'b0); // open access
      wb(8'h66, 1'b0); // low bit differs
      op(RSS_OP_START, 8'h00, 1'b0); // repeated start
      wb(8'hE4, 1'b0); // top bit differs
      stop();
      // Stalled access ends on its own; repeated start must not extend it
      op(RSS_OP_START, 8'h00, 1'b0); // open access
      t0 = $time;
      wb(8'h64, 1'b1); // own address
      wb(8'hE0, 1'b1); // pointer byte
      op(RSS_OP_START, 8'h00, 1'b0); // repeated start
      wb(8'h64, 1'b1); // address again
      n = 0;
      while (freeze !== 1'b0 && n < 12000) begin
         n++;
         @(negedge clk);
      end
      n = int'(($time - t0) / 40);
      `CHK(n > TO_LINK * 4 - 100 && n < TO_LINK * 4 + 100, 1'b1) // from first start
      wb(8'h5A, 1'b0); // write refused
      rd(1'b1, 8'hFF); // read all ones
      stop();
      op(RSS_OP_START, 8'h00, 1'b0);
      wb(8'h64, 1'b1); // usable after stop
      stop();
      finish_test();
   end
endmodule
`default_nettype wire
